// File: rtl/tsdm_bcd_reg.sv
`timescale 1ns/1ps
`default_nettype none
module tsdm_bcd_reg #(
  parameter int W = 6
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // load and clear from the steering logic
  tsdm_cap_if.store cap
);
  import tsdm_pkg::*;

  logic [W-1:0] value;

  // capture has priority over clear so an event is never lost
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      value <= '0;
    end else if (cap.load) begin
      value <= cap.din;
    end else if (cap.clear) begin
      value <= '0;
    end
  end

  assign cap.q = value;

  property p_load_takes;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      cap.load |=> (value == $past(cap.din));
  endproperty
  a_load_takes: assert property (p_load_takes)
    else $error("load did not store input digits");

  property p_hold_idle;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (!cap.load && !cap.clear) |=> $stable(value);
  endproperty
  a_hold_idle: assert property (p_hold_idle)
    else $error("stored digits changed without load or clear");
endmodule : tsdm_bcd_reg
`default_nettype wire

// File: rtl/tsdm_cap_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tsdm_cap_if #(
  parameter int W = 8
);
  logic load;
  logic clear;
  logic [W-1:0] din;
  logic [W-1:0] q;
  // steering side decides when to load or clear
  modport ctrl (output load, output clear, output din, input q);
  // storage side holds the captured digits
  modport store (input load, input clear, input din, output q);
endinterface : tsdm_cap_if
`default_nettype wire

// File: rtl/tsdm_capture.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - each captured value is two BCD digits, tens high, units in low nibble.
// - captured day holds 01 to 31 in bits 5:0, tens in bits 5:4.
// - captured month holds 01 to 12 in bits 4:0, tens in bit 4.
// - both registers are read only; writes change nothing and have no effect.
// - day bits 7:6 and month bits 7:5 always read zero.
// - a one written to the clear control sets both registers to 00h unless a capture is taken in the same cycle.
// - when enabled, overwrite select keeps first event or updates on each later one.
module tsdm_capture (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // live calendar digits from the time base
  input wire logic [tsdm_pkg::DAY_W-1:0] cal_day_i,
  input wire logic [tsdm_pkg::MONTH_W-1:0] cal_month_i,
  // event logic controls
  input wire logic capture_strobe_i,
  input wire logic capture_enable_bit_i,
  input wire logic overwrite_select_bit_i,
  input wire logic capture_clear_bit_i,
  // register access port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [tsdm_pkg::DATA_W-1:0] reg_wdata_i,
  output logic [tsdm_pkg::DATA_W-1:0] reg_rdata_o,
  output logic reg_rd_ack_o,
  // captured state for the rest of the time-stamp logic
  output logic captured_o
);
  import tsdm_pkg::*;

  tsdm_cap_if #(.W(DAY_W)) day_if ();
  tsdm_cap_if #(.W(MONTH_W)) month_if ();

  logic captured;
  logic cap_go;
  logic [DATA_W-1:0] next_rdata;

  assign cap_go = capture_strobe_i && capture_enable_bit_i
                  && (overwrite_select_bit_i || !captured);

  // digits pass through in BCD order
  assign day_if.din = cal_day_i;
  assign month_if.din = cal_month_i;
  assign day_if.load = cap_go;
  assign month_if.load = cap_go;
  assign day_if.clear = capture_clear_bit_i;
  assign month_if.clear = capture_clear_bit_i;

  // captured day storage
  tsdm_bcd_reg #(.W(DAY_W)) u_day (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .cap(day_if.store)
  );

  // captured month storage
  tsdm_bcd_reg #(.W(MONTH_W)) u_month (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .cap(month_if.store)
  );

  // first capture marker, set wins over clear
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      captured <= 1'b0;
    end else if (cap_go) begin
      captured <= 1'b1;
    end else if (capture_clear_bit_i) begin
      captured <= 1'b0;
    end
  end

  always_comb begin
    next_rdata = RESET_VAL;
    unique case (reg_addr_i)
      ADDR_DAY: next_rdata = {{(DATA_W-DAY_W){1'b0}}, day_if.q};
      ADDR_MONTH: next_rdata = {{(DATA_W-MONTH_W){1'b0}}, month_if.q};
      default: next_rdata = RESET_VAL;
    endcase
  end

  // read answer; writes are not decoded at all
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= RESET_VAL;
      reg_rd_ack_o <= 1'b0;
    end else begin
      reg_rd_ack_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // captured flag output
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      captured_o <= 1'b0;
    end else begin
      captured_o <= (cap_go || (captured && !capture_clear_bit_i));
    end
  end

  property p_clear_zero;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (capture_clear_bit_i && !cap_go) |=> (day_if.q == DAY_CLR && month_if.q == MONTH_CLR);
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("clear did not zero captured registers");

  property p_keep_first;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (captured && !overwrite_select_bit_i && !capture_clear_bit_i)
        |=> ($stable(day_if.q) && $stable(month_if.q));
  endproperty
  a_keep_first: assert property (p_keep_first)
    else $error("first event was overwritten");

  property p_keep_last;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (capture_strobe_i && capture_enable_bit_i && overwrite_select_bit_i)
        |=> (day_if.q == $past(cal_day_i) && month_if.q == $past(cal_month_i));
  endproperty
  a_keep_last: assert property (p_keep_last)
    else $error("last event not stored");

  property p_disabled_hold;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (!capture_enable_bit_i && !capture_clear_bit_i) |=> $stable(day_if.q);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold)
    else $error("capture while disabled");

  property p_write_none;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (reg_wr_i && !cap_go && !capture_clear_bit_i)
        |=> ($stable(day_if.q) && $stable(month_if.q));
  endproperty
  a_write_none: assert property (p_write_none)
    else $error("write changed a captured register");

  property p_read_day;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (reg_rd_i && reg_addr_i == ADDR_DAY)
        |=> (reg_rd_ack_o && reg_rdata_o == {2'h0, $past(day_if.q)});
  endproperty
  a_read_day: assert property (p_read_day)
    else $error("day read returned wrong value");

  property p_read_month;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (reg_rd_i && reg_addr_i == ADDR_MONTH)
        |=> (reg_rdata_o[7:5] == 3'h0 && reg_rdata_o[4:0] == $past(month_if.q));
  endproperty
  a_read_month: assert property (p_read_month)
    else $error("month read returned wrong value");

  property p_upper_zero;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      reg_rd_ack_o |-> (reg_rdata_o[7:6] == 2'h0);
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("unused upper bits not zero");

  property p_first_after_clear;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (!captured && capture_strobe_i && capture_enable_bit_i)
        |=> (captured_o && day_if.q == $past(cal_day_i));
  endproperty
  a_first_after_clear: assert property (p_first_after_clear)
    else $error("first capture not taken");

  property p_write_no_ack;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (reg_wr_i && !reg_rd_i) |=> !reg_rd_ack_o;
  endproperty
  a_write_no_ack: assert property (p_write_no_ack)
    else $error("write produced a read answer");

  property p_rdata_hold;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  property p_load_month;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      cap_go |=> (month_if.q == $past(cal_month_i));
  endproperty
  a_load_month: assert property (p_load_month)
    else $error("month digits not captured");

  property p_clear_marker;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (capture_clear_bit_i && !cap_go) |=> !captured_o;
  endproperty
  a_clear_marker: assert property (p_clear_marker)
    else $error("capture marker kept after clear");

  property p_capture_wins;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (capture_clear_bit_i && cap_go)
        |=> (captured_o && day_if.q == $past(cal_day_i));
  endproperty
  a_capture_wins: assert property (p_capture_wins)
    else $error("clear overrode a same cycle capture");
endmodule : tsdm_capture
`default_nettype wire

// File: rtl/tsdm_pkg.sv
package tsdm_pkg;
  // register map of the captured calendar bytes
  localparam logic [7:0] ADDR_DAY = 8'h18;
  localparam logic [7:0] ADDR_MONTH = 8'h19;
  // register and field widths
  localparam int DATA_W = 8;
  localparam int DAY_W = 6;
  localparam int MONTH_W = 5;
  // values after reset and after a clear
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [5:0] DAY_CLR = 6'h00;
  localparam logic [4:0] MONTH_CLR = 5'h00;
  // read answer latency in clock cycles
  localparam int READ_LAT = 1;
endpackage : tsdm_pkg

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [5:0] cal_day = 6'h00;
  logic [4:0] cal_month = 5'h00;
  logic strobe = 1'b0;
  logic enable = 1'b0;
  logic ow_sel = 1'b0;
  logic clr = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic rd, wr, ack, captured;
  int bad_count = 0;
  int checked = 0;
  // clock
  always #5 ref_clk_i = ~ref_clk_i;
  tsdm_capture dut_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .cal_day_i(cal_day), .cal_month_i(cal_month), .capture_strobe_i(strobe),
    .capture_enable_bit_i(enable), .overwrite_select_bit_i(ow_sel),
    .capture_clear_bit_i(clr), .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rd_ack_o(ack), .captured_o(captured));
  tsdm_host_model host_u (.clk_i(ref_clk_i), .reg_addr_o(addr), .reg_rd_o(rd),
    .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rd_ack_i(ack));
  // read one byte and compare
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic k;
    host_u.read(a, d, k);
    `CHK(k, 1'b1)
    `CHK(d, e)
  endtask
  // one event with given live digits and controls
  task automatic evt(input logic [5:0] dy, input logic [4:0] mo, input logic en,
    input logic ow);
    @(negedge ref_clk_i);
    cal_day = dy;
    cal_month = mo;
    enable = en;
    ow_sel = ow;
    strobe = 1'b1;
    @(negedge ref_clk_i);
    strobe = 1'b0;
    cal_day = ~dy; // live calendar moves on
    cal_month = ~mo;
  endtask
  task automatic t_reset;
    rdc(8'h18, 8'h00);
    rdc(8'h19, 8'h00);
    rdc(8'h1a, 8'h00);
  endtask
  task automatic t_capture;
    evt(6'h31, 5'h12, 1'b1, 1'b0);
    `CHK(captured, 1'b1)
    rdc(8'h18, 8'h31);
    rdc(8'h19, 8'h12);
  endtask
  task automatic t_modes;
    evt(6'h07, 5'h09, 1'b1, 1'b0);
    rdc(8'h18, 8'h31);
    evt(6'h07, 5'h09, 1'b0, 1'b1);
    rdc(8'h19, 8'h12);
    evt(6'h07, 5'h09, 1'b1, 1'b1);
    rdc(8'h18, 8'h07);
    rdc(8'h19, 8'h09);
  endtask
  task automatic t_write;
    host_u.write(8'h18, 8'hff);
    host_u.write(8'h19, 8'hff);
    `CHK(ack, 1'b0)
    rdc(8'h18, 8'h07);
    rdc(8'h19, 8'h09);
  endtask
  task automatic t_clear;
    @(negedge ref_clk_i);
    clr = 1'b1;
    @(negedge ref_clk_i);
    clr = 1'b0;
    `CHK(captured, 1'b0)
    rdc(8'h18, 8'h00);
    rdc(8'h19, 8'h00);
    evt(6'h01, 5'h01, 1'b1, 1'b0);
    rdc(8'h18, 8'h01);
  endtask
  // capture and clear in one cycle: capture wins
  task automatic t_collide;
    @(negedge ref_clk_i);
    cal_day = 6'h15;
    cal_month = 5'h05;
    enable = 1'b1;
    ow_sel = 1'b1;
    strobe = 1'b1;
    clr = 1'b1;
    @(negedge ref_clk_i);
    strobe = 1'b0;
    clr = 1'b0;
    `CHK(captured, 1'b1)
    rdc(8'h18, 8'h15);
    rdc(8'h19, 8'h05);
  endtask
  // reset again in mid-run
  task automatic t_rerst;
    @(negedge ref_clk_i);
    sys_rst_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    `CHK(captured, 1'b0)
    rdc(8'h18, 8'h00);
    rdc(8'h19, 8'h00);
  endtask
  // verdict and end of run
  task automatic tally_and_finish;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_capture();
    t_modes();
    t_write();
    t_clear();
    t_collide();
    t_rerst();
    tally_and_finish();
  end
  // watchdog
  initial begin
    #5000;
    bad_count++;
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire

// File: verif/tsdm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsdm_host_model (
  // clock
  input wire logic clk_i,
  // register port toward the block
  output logic [7:0] reg_addr_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rd_ack_i
);
  // idle bus with strobes low
  initial begin
    reg_addr_o = 8'h00;
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // one read, answer taken a cycle after the strobe
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ack);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_i);
    d = reg_rdata_i;
    ack = reg_rd_ack_i;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a; // released address does not linger
  endtask
  // one write strobe with data
  task automatic write(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = v;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~v;
  endtask
endmodule // tsdm_host_model
`default_nettype wire
